// File: src/fac_pkg.sv
// Package of constants for the flash array control block
package fac_pkg;

  // ==========================================================
  // Address map
  localparam logic [15:0] USER_LO      = 16'h8000;
  localparam logic [15:0] USER_HI      = 16'hFDFF;
  localparam logic [15:0] PROT1_ADDR   = 16'hFF80;
  localparam logic [15:0] PROT2_ADDR   = 16'hFF81;
  localparam logic [15:0] CTRL_ADDR    = 16'hFF88;
  localparam logic [15:0] VEC_LO       = 16'hFFCC;
  localparam logic [15:0] VEC_HI       = 16'hFFFF;
  localparam logic [15:0] STATUS_ADDR  = 16'hFF8C;

  // ==========================================================
  // Array geometry
  localparam int ARRAY_BYTES = 32256;
  localparam int ROW_BYTES   = 64;
  localparam int PAGE_BYTES  = 128;
  localparam int ROW_LSB     = 6;
  localparam int PAGE_LSB    = 7;

  // ==========================================================
  // Control register fields and values
  localparam int BIT_PGM  = 0;
  localparam int BIT_ERS  = 1;
  localparam int BIT_MASS = 2;
  localparam int BIT_HIGH_VOLTAGE_ENABLE = 3;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] ERASED     = 8'hFF;
  localparam logic [7:0] PROT_NONE  = 8'hFF;

  // ==========================================================
  // Step states of the program or erase sequence
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SELECTED,
    SEQ_PROT_READ,
    SEQ_LATCHED
  } fac_seq_e;

endpackage : fac_pkg

// File: src/fac_array_mem.sv
// Byte array storage with erased-one and program-to-zero behaviour
`timescale 1ns/1ps
module fac_array_mem #(
  parameter int DEPTH = 32768,
  parameter int AW    = 15
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o,
  // Program port
  input  wire logic          prog_i,
  input  wire logic [AW-1:0] paddr_i,
  input  wire logic [7:0]    pdata_i,
  // Erase port
  input  wire logic          erase_i,
  input  wire logic          mass_i,
  input  wire logic [AW-1:0] eaddr_i
);

  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Programming only clears bits; erase returns them to one
  // Only reset and mass erase sweep the whole array, a page erase touches one page
  always_ff @(posedge clk_i) begin
    if (rst_i || (erase_i && mass_i)) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= fac_pkg::ERASED;
      end
    end else if (erase_i) begin
      for (int j = 0; j < fac_pkg::PAGE_BYTES; j++) begin
        mem[{eaddr_i[AW-1:fac_pkg::PAGE_LSB], j[fac_pkg::PAGE_LSB-1:0]}] <= fac_pkg::ERASED;
      end
    end else if (prog_i) begin
      mem[paddr_i] <= mem[paddr_i] & pdata_i;
    end
  end

  // Registered read data
  always_comb begin
    rdata_next = mem[raddr_i];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= fac_pkg::ERASED;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

endmodule : fac_array_mem

// File: src/fac_timer.sv
// Down counter that times the high-voltage pulse
`timescale 1ns/1ps
module fac_timer #(
  parameter int W = 20
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  // Status
  output logic              done_o
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Load or count down to zero
  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = count_i;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done_o = (cnt_reg == '0);

endmodule : fac_timer

// File: src/flash_array_control.sv
// Flash array control: address decode, control register and sequencing
`timescale 1ns/1ps
module flash_array_control #(
  parameter int unsigned HV_CYCLES = 20
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [7:0]  dat_i,
  input  wire logic        sel_i,
  output logic      [7:0]  dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Analog controls
  output logic             charge_pump_on_o,
  output logic             high_voltage_o
);

  // ==========================================================
  // Declarations
  localparam int AW = 15;

  logic [7:0]            prot1_reg;
  logic [7:0]            prot1_next;
  logic [7:0]            prot2_reg;
  logic [7:0]            prot2_next;
  logic                  program_select_reg;
  logic                  program_select_next;
  logic                  erase_select_reg;
  logic                  erase_select_next;
  logic                  mass_reg;
  logic                  mass_next;
  logic                  high_voltage_enable_reg;
  logic                  high_voltage_enable_next;
  logic                  busy_reg;
  logic                  busy_next;
  fac_pkg::fac_seq_e     seq_reg;
  fac_pkg::fac_seq_e     seq_next;
  logic [15:0]           target_reg;
  logic [15:0]           target_next;
  logic                  ack_reg;
  logic                  ack_next;
  logic                  err_reg;
  logic                  err_next;
  logic                  rd_pend_reg;
  logic                  rd_pend_next;
  logic [7:0]            dat_reg;
  logic [7:0]            dat_next;
  logic                  mem_prog;
  logic                  mem_erase;
  logic [7:0]            mem_rdata;
  logic                  timer_load;
  logic                  timer_done;
  logic                  req;
  logic                  in_user;
  logic                  in_vec;
  logic                  in_array;
  logic                  hit_ctrl;
  logic                  hit_p1;
  logic                  hit_p2;
  logic                  hit_stat;
  logic                  mapped;
  logic [15:0]           prot_start;
  logic                  target_protected;
  logic                  row_ok;
  logic [7:0]            ctrl_rd;
  logic                  hit_prot;
  logic                  prot_prog;
  logic                  prot_erase;

  // ==========================================================
  // Address decode
  // A request counts only while no answer stands, so each is served once
  assign req      = cyc_i && stb_i && !ack_reg && !err_reg;
  assign in_user  = (adr_i >= fac_pkg::USER_LO) && (adr_i <= fac_pkg::USER_HI);
  assign in_vec   = (adr_i >= fac_pkg::VEC_LO) && (adr_i <= fac_pkg::VEC_HI);
  assign in_array = in_user || in_vec;
  assign hit_p1   = (adr_i == fac_pkg::PROT1_ADDR);
  assign hit_p2   = (adr_i == fac_pkg::PROT2_ADDR);
  assign hit_ctrl = (adr_i == fac_pkg::CTRL_ADDR);
  assign hit_stat = (adr_i == fac_pkg::STATUS_ADDR);
  assign mapped   = in_array || hit_p1 || hit_p2 || hit_ctrl || hit_stat;
  assign hit_prot = hit_p1 || hit_p2;

  // Protect start address from the protect byte
  assign prot_start = {1'b1, prot1_reg, 7'h00};
  // All ones means no protection at all
  // Mass erase would reach the protected pages too, so any protection refuses it
  assign target_protected = (prot1_reg != fac_pkg::PROT_NONE) &&
                            (mass_reg || (target_reg >= prot_start));

  // Control register image
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[fac_pkg::BIT_PGM]  = program_select_reg;
    ctrl_rd[fac_pkg::BIT_ERS]  = erase_select_reg;
    ctrl_rd[fac_pkg::BIT_MASS] = mass_reg;
    ctrl_rd[fac_pkg::BIT_HIGH_VOLTAGE_ENABLE] = high_voltage_enable_reg;
  end

  // Program stays within the latched row
  // Writes outside that row are acked and dropped
  assign row_ok = (adr_i[15:fac_pkg::ROW_LSB] == target_reg[15:fac_pkg::ROW_LSB]);

  // Erasing the top page or the whole array erases the protect bytes too
  assign prot_erase = mem_erase && (mass_reg ||
                      (target_reg[15:fac_pkg::PAGE_LSB] ==
                       fac_pkg::PROT1_ADDR[15:fac_pkg::PAGE_LSB]));

  // ==========================================================
  // Bus and control next-state
  always_comb begin
    program_select_next      = program_select_reg;
    erase_select_next        = erase_select_reg;
    mass_next                = mass_reg;
    high_voltage_enable_next = high_voltage_enable_reg;
    seq_next                 = seq_reg;
    target_next              = target_reg;
    ack_next                 = 1'b0;
    err_next                 = 1'b0;
    rd_pend_next             = 1'b0;
    dat_next                 = dat_reg;
    mem_prog                 = 1'b0;
    mem_erase                = 1'b0;
    timer_load               = 1'b0;
    prot_prog                = 1'b0;
    // Array read data arrives one cycle after the request
    if (rd_pend_reg) begin
      dat_next = mem_rdata;
      ack_next = 1'b1;
    end else if (req && !mapped) begin
      err_next = 1'b1;
    end else if (req && we_i) begin
      ack_next = 1'b1;
      if (hit_ctrl && sel_i) begin
        // Mutual lockout: each select sets only when the other is not already set; both at once change neither
        if (dat_i[fac_pkg::BIT_PGM] && dat_i[fac_pkg::BIT_ERS]) begin
          program_select_next = program_select_reg;
          erase_select_next   = erase_select_reg;
        end else if (dat_i[fac_pkg::BIT_PGM]) begin
          program_select_next = !erase_select_reg;
        end else if (dat_i[fac_pkg::BIT_ERS]) begin
          erase_select_next   = !program_select_reg;
        end else begin
          program_select_next = 1'b0;
          erase_select_next   = 1'b0;
        end
        if (!dat_i[fac_pkg::BIT_PGM]) begin
          program_select_next = 1'b0;
        end
        if (!dat_i[fac_pkg::BIT_ERS]) begin
          erase_select_next = 1'b0;
        end
        mass_next = dat_i[fac_pkg::BIT_MASS];
        // Selection change restarts the sequence
        if ((program_select_next || erase_select_next) &&
            !(program_select_reg || erase_select_reg)) begin
          seq_next = fac_pkg::SEQ_SELECTED;
        end else if (!program_select_next && !erase_select_next &&
                     !high_voltage_enable_reg) begin
          seq_next = fac_pkg::SEQ_IDLE;
        end
        if (!dat_i[fac_pkg::BIT_HIGH_VOLTAGE_ENABLE]) begin
          high_voltage_enable_next = 1'b0;
          // Dropping high voltage ends the operation; the next one starts from select
          if (high_voltage_enable_reg && seq_next == fac_pkg::SEQ_LATCHED) begin
            seq_next = fac_pkg::SEQ_IDLE;
          end
        end else if ((program_select_reg || erase_select_reg) &&
                     seq_reg == fac_pkg::SEQ_LATCHED && !target_protected) begin
          high_voltage_enable_next = 1'b1;
          // Erase pulse is timed and applied once
          if (erase_select_reg && !high_voltage_enable_reg) begin
            mem_erase  = 1'b1;
            timer_load = 1'b1;
          end
        end
      end else if ((in_array || hit_prot) && sel_i) begin
        if (!program_select_reg && !erase_select_reg) begin
          target_next = target_reg;
        end else if (seq_reg == fac_pkg::SEQ_PROT_READ) begin
          target_next = adr_i;
          seq_next    = fac_pkg::SEQ_LATCHED;
        end else if (program_select_reg && high_voltage_enable_reg &&
                     row_ok && !busy_reg) begin
          mem_prog   = in_array;
          prot_prog  = hit_prot;
          timer_load = 1'b1;
        end
      end
    end else if (req) begin
      ack_next = 1'b1;
      if (in_array) begin
        ack_next     = 1'b0;
        rd_pend_next = 1'b1;
      end else if (hit_p1) begin
        dat_next = prot1_reg;
        if (seq_reg == fac_pkg::SEQ_SELECTED) begin
          seq_next = fac_pkg::SEQ_PROT_READ;
        end
      end else if (hit_p2) begin
        dat_next = prot2_reg;
      end else if (hit_ctrl) begin
        dat_next = ctrl_rd;
      end else begin
        dat_next = {7'h00, busy_reg};
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_select_reg      <= 1'b0;
      erase_select_reg        <= 1'b0;
      mass_reg                <= 1'b0;
      high_voltage_enable_reg <= 1'b0;
      seq_reg                 <= fac_pkg::SEQ_IDLE;
      target_reg              <= 16'h0000;
      ack_reg                 <= 1'b0;
      err_reg                 <= 1'b0;
      rd_pend_reg             <= 1'b0;
      dat_reg                 <= 8'h00;
    end else begin
      program_select_reg      <= program_select_next;
      erase_select_reg        <= erase_select_next;
      mass_reg                <= mass_next;
      high_voltage_enable_reg <= high_voltage_enable_next;
      seq_reg                 <= seq_next;
      target_reg              <= target_next;
      ack_reg                 <= ack_next;
      err_reg                 <= err_next;
      rd_pend_reg             <= rd_pend_next;
      dat_reg                 <= dat_next;
    end
  end

  // ==========================================================
  // Protect bytes
  // They sit in the top page: programming only clears bits, erase sets all
  // Leaving that page unprotected lets an erase there remove all protection
  always_comb begin
    prot1_next = prot1_reg;
    prot2_next = prot2_reg;
    if (prot_erase) begin
      prot1_next = fac_pkg::ERASED;
      prot2_next = fac_pkg::ERASED;
    end else if (prot_prog && hit_p1) begin
      prot1_next = prot1_reg & dat_i;
    end else if (prot_prog && hit_p2) begin
      prot2_next = prot2_reg & dat_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prot1_reg <= fac_pkg::PROT_NONE;
      prot2_reg <= fac_pkg::PROT_NONE;
    end else begin
      prot1_reg <= prot1_next;
      prot2_reg <= prot2_next;
    end
  end

  // ==========================================================
  // Pulse busy flag
  // Busy from the start of a timed pulse until the timer runs out
  // Array writes during a pulse are acked but not programmed
  always_comb begin
    busy_next = busy_reg;
    if (timer_load) begin
      busy_next = 1'b1;
    end else if (timer_done) begin
      busy_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  // ==========================================================
  // Storage and pulse timer
  // Array writes reach storage only through the sequence gates
  fac_array_mem #(
    .DEPTH (32768),
    .AW    (AW)
  ) u_mem (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raddr_i (adr_i[AW-1:0]),
    .rdata_o (mem_rdata),
    .prog_i  (mem_prog),
    .paddr_i (adr_i[AW-1:0]),
    .pdata_i (dat_i),
    .erase_i (mem_erase),
    .mass_i  (mass_reg),
    .eaddr_i (target_reg[AW-1:0])
  );

  fac_timer #(
    .W (20)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (timer_load),
    .count_i (20'(HV_CYCLES)),
    .done_o  (timer_done)
  );

  // Outputs
  // Pump and high voltage follow one bit, so they always agree
  assign dat_o            = dat_reg;
  assign ack_o            = ack_reg;
  assign err_o            = err_reg;
  assign charge_pump_on_o = high_voltage_enable_reg;
  assign high_voltage_o   = high_voltage_enable_reg;

endmodule : flash_array_control

// File: verification/fac_sva.sv
// Checker for the flash array control ports
`timescale 1ns/1ps
module fac_sva (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [15:0] adr_i,
  input wire logic [7:0]  dat_i,
  input wire logic        sel_i,
  input wire logic [7:0]  dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  // Analog controls
  input wire logic        charge_pump_on_o,
  input wire logic        high_voltage_o
);
  // ==========================================================
  // Helpers
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic ctl;
  // New request and control decode
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign ctl = adr_i == fac_pkg::CTRL_ADDR;

  // ==========================================================
  // Assertions
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ctrl_ack: assert property (req && ctl |=> ack_o && !err_o)
    else $error("control access not acked next cycle");
  a_array_rd: assert property (req && !$past(req) && !we_i && adr_i >= fac_pkg::USER_LO
    && adr_i <= fac_pkg::USER_HI |=> !ack_o ##1 ack_o)
    else $error("array read latency wrong");
  a_vec_rd: assert property (req && !$past(req) && !we_i && adr_i >= fac_pkg::VEC_LO
    |=> !err_o ##1 ack_o)
    else $error("vector read not served by array");
  a_unmapped_err: assert property (req && adr_i == 16'hFF90 |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  a_pump_tied: assert property (charge_pump_on_o == high_voltage_o)
    else $error("pump and high voltage disagree");
  a_hv_cause: assert property ($rose(high_voltage_o)
    |-> $past(req && we_i && sel_i && ctl && dat_i[3]))
    else $error("high voltage rose without control write");
  a_hv_clear: assert property (req && we_i && sel_i && ctl && !dat_i[3]
    |=> !high_voltage_o)
    else $error("high voltage stayed on after clear");
  a_sel_lock: assert property (ack_o && $past(ctl && !we_i)
    |-> !(dat_o[0] && dat_o[1]))
    else $error("program and erase both selected");

  // ==========================================================
  // Coverage
  c_hv_on: cover property ($rose(high_voltage_o));
  c_err: cover property (err_o);
  c_prog_rd: cover property (ack_o && dat_o == 8'h3C);
endmodule : fac_sva

// File: verification/fac_cpu_model.sv
// Processor core memory bus model issuing classic single cycles
`timescale 1ns/1ps
module fac_cpu_model (
  // Clock
  input  wire logic        clk_i,
  // Answer from the block
  input  wire logic [7:0]  dat_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  // Request to the block
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [15:0]      adr_o,
  output logic [7:0]       dat_o,
  output logic             sel_o
);
  // Idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 16'h0000;
    dat_o = 8'h00;
    sel_o = 1'b0;
  end

  // One cycle: raise after an edge, hold until answered, then release
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic e);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    sel_o <= 1'b1;
    do @(posedge clk_i); while (!(ack_i || err_i));
    q = dat_i;
    e = err_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    adr_o <= ~a;  // Released lines show no stale value
    dat_o <= ~d;
  endtask : xfer
endmodule : fac_cpu_model

// File: verification/flash_array_control_bench.sv
// Self-checking bench for the flash array control block
`timescale 1ns/1ps
module flash_array_control_bench;
  // ==========================================================
  // Signals
  localparam logic [15:0] CR = fac_pkg::CTRL_ADDR;
  localparam logic [15:0] PR = fac_pkg::PROT1_ADDR;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, sel, ack, err, pump, hv;
  logic [15:0] adr;
  logic [7:0]  wdat, rdat;
  logic [7:0]  prot_exp = 8'hFF;
  int          n_fail = 0;
  int          checks_done = 0;

  // Clock of 50 ns period
  always #25 clk_i = ~clk_i;

  // ==========================================================
  // Instances
  fac_cpu_model cpu (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .err_i(err),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wdat), .sel_o(sel));
  flash_array_control #(.HV_CYCLES(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel),
    .dat_o(rdat), .ack_o(ack), .err_o(err), .charge_pump_on_o(pump),
    .high_voltage_o(hv));

  // ==========================================================
  // Helper tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       e;
    cpu.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       e;
    cpu.xfer(1'b0, a, 8'h00, q, e);
    chk(q, exp);
  endtask : rdc

  task automatic errc(input logic [15:0] a);
    logic [7:0] q;
    logic       e;
    cpu.xfer(1'b0, a, 8'h00, q, e);
    chk({7'h00, e}, 8'h01);
  endtask : errc

  // Poll the busy flag until the pulse ends
  task automatic wait_idle;
    logic [7:0] q;
    logic       e;
    do cpu.xfer(1'b0, fac_pkg::STATUS_ADDR, 8'h00, q, e); while (q[0] !== 1'b0);
  endtask : wait_idle

  // Select, read protect, latch target, raise high voltage, then act
  task automatic hv_op(input logic [7:0] s, input logic [15:0] l,
                       input logic [15:0] a, input logic [7:0] d);
    wr(CR, s);
    rdc(PR, prot_exp);
    wr(l, 8'h00);
    wr(CR, s | 8'h08);
    chk({7'h00, hv}, 8'h01);
    chk({7'h00, pump}, 8'h01);
    if (s[0]) wr(a, d);
    wait_idle;
    wr(CR, 8'h00);
    chk({7'h00, hv}, 8'h00);
    chk({7'h00, pump}, 8'h00);
  endtask : hv_op

  // ==========================================================
  // Scenarios
  task automatic t_map;
    rdc(CR, 8'h00);
    rdc(16'hFF81, 8'hFF);
    rdc(16'h8000, 8'hFF);
    rdc(16'hFDFF, 8'hFF);
    rdc(16'hFFFE, 8'hFF);
    errc(16'hFF90);
    errc(16'h7FFF);
    wr(PR, 8'h00);
    rdc(PR, 8'hFF);
  endtask : t_map

  task automatic t_lock;
    wr(CR, 8'h03);
    rdc(CR, 8'h00);
    wr(CR, 8'h01);
    wr(CR, 8'h03);
    rdc(CR, 8'h01);
    wr(CR, 8'h09);
    chk({7'h00, hv}, 8'h00);
    wr(CR, 8'h08);
    rdc(CR, 8'h00);
    wr(CR, 8'h04);
    rdc(CR, 8'h04);
    wr(CR, 8'h00);
    wr(16'h8100, 8'h00);
    rdc(16'h8100, 8'hFF);
  endtask : t_lock

  task automatic t_prog;
    hv_op(8'h01, 16'h8041, 16'h8041, 8'h3C);
    hv_op(8'h01, 16'h80C0, 16'h80C0, 8'h0F);
    hv_op(8'h01, 16'h8000, 16'h8080, 8'h00);
    rdc(16'h8041, 8'h3C);
    rdc(16'h8040, 8'hFF);
    rdc(16'h8080, 8'hFF);
    hv_op(8'h01, 16'h8041, 16'h8041, 8'hF0);
    rdc(16'h8041, 8'h30);
  endtask : t_prog

  task automatic t_erase;
    hv_op(8'h02, 16'h8010, 16'h0000, 8'h00);
    rdc(16'h8041, 8'hFF);
    rdc(16'h80C0, 8'h0F);
    hv_op(8'h06, 16'h8010, 16'h0000, 8'h00);
    rdc(16'h80C0, 8'hFF);
  endtask : t_erase

  // Program the protect byte, then protected targets refuse high voltage
  task automatic t_prot;
    hv_op(8'h01, PR, PR, 8'h02);
    prot_exp = 8'h02;
    rdc(PR, 8'h02);
    wr(CR, 8'h01);
    rdc(PR, 8'h02);
    wr(16'h8100, 8'h00);
    wr(CR, 8'h09);
    chk({7'h00, hv}, 8'h00);
    wr(CR, 8'h00);
    wr(CR, 8'h06);
    rdc(PR, 8'h02);
    wr(16'h8000, 8'h00);
    wr(CR, 8'h0E);
    chk({7'h00, hv}, 8'h00);
    wr(CR, 8'h00);
    hv_op(8'h01, 16'h80FF, 16'h80FF, 8'h5A);
    rdc(16'h80FF, 8'h5A);
  endtask : t_prot

  // ==========================================================
  // Verdict and run control
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Watchdog over the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    close_out;
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_map;
    t_lock;
    t_prog;
    t_erase;
    t_prot;
    close_out;
  end
endmodule : flash_array_control_bench

bind flash_array_control fac_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
  .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .charge_pump_on_o(charge_pump_on_o),
  .high_voltage_o(high_voltage_o));
